// >>> design/pts_controller.sv
`timescale 1ns/1ps
module pts_controller
	import pts_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	pts_link_if.host         lnk
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PTS_ST_IDLE = 3'b001,
		PTS_ST_WAIT = 3'b010,
		PTS_ST_DONE = 3'b100
	} pts_ctl_phase_type;

	typedef struct packed {
		pts_ctl_phase_type      phase;
		logic                   req;
		logic                   we;
		logic [11:0]            addr;
		logic [31:0]            wdata;
		logic [31:0]            rdata;
		logic                   frm_valid;
		logic [31:0]            frame_cmd;
		logic [PTS_CNT_W-1:0]   snap_cnt;
		logic                   irq_seen;
		logic [31:0]            snap_sec;
		logic [PTS_SUB_W-1:0]   snap_sub;
	} pts_ctl_state_type;

	pts_ctl_state_type st_ff;
	pts_ctl_state_type nxt_st;
	logic              access;

	assign access = psel && penable && (st_ff.phase == PTS_ST_DONE);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.req = 1'b0;
		nxt_st.frm_valid = 1'b0;
		if (lnk.snap_valid) begin
			nxt_st.snap_cnt = st_ff.snap_cnt + 16'h1;
			nxt_st.snap_sec = lnk.snap_sec;
			nxt_st.snap_sub = lnk.snap_sub;
		end
		unique case (st_ff.phase)
			PTS_ST_IDLE: begin
				if (psel && !penable) begin
					nxt_st.we = pwrite;
					nxt_st.addr = paddr[11:0];
					nxt_st.wdata = pwdata;
					nxt_st.rdata = '0;
					if (!paddr[PTS_LOCAL_BIT]) begin
						// device requests are forwarded as-is; software itself must
						// poll the self-clearing request bits before setting them
						nxt_st.req = 1'b1;
						nxt_st.phase = PTS_ST_WAIT;
					end else begin
						unique case (paddr[11:0])
							PTS_OFS_FRAME:    nxt_st.rdata = st_ff.frame_cmd;
							PTS_OFS_STATUS:   nxt_st.rdata = {15'h0, st_ff.irq_seen, st_ff.snap_cnt};
							PTS_OFS_SNAP_SEC: nxt_st.rdata = st_ff.snap_sec;
							PTS_OFS_SNAP_SUB: nxt_st.rdata = {1'b0, st_ff.snap_sub};
							default:          nxt_st.rdata = '0;
						endcase
						nxt_st.phase = PTS_ST_DONE;
					end
				end
			end
			PTS_ST_WAIT: begin
				if (lnk.reg_ack) begin
					nxt_st.rdata = lnk.reg_rdata;
					nxt_st.phase = PTS_ST_DONE;
				end
			end
			PTS_ST_DONE: begin
				if (access) begin
					nxt_st.phase = PTS_ST_IDLE;
					if (st_ff.we && st_ff.addr == PTS_OFS_FRAME) begin
						nxt_st.frame_cmd = st_ff.wdata;
						nxt_st.frm_valid = 1'b1;
					end
					if (st_ff.we && st_ff.addr == PTS_OFS_STATUS && st_ff.wdata[PTS_S_IRQ])
						nxt_st.irq_seen = 1'b0;
				end
			end
		endcase
		// an interrupt in the clearing cycle is kept
		if (lnk.trig_irq)
			nxt_st.irq_seen = 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_ff <= '0;
			st_ff.phase <= PTS_ST_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign pready            = (st_ff.phase == PTS_ST_DONE);
	assign prdata            = st_ff.rdata;
	assign pslverr           = 1'b0;
	assign lnk.reg_req       = st_ff.req;
	assign lnk.reg_we        = st_ff.we;
	assign lnk.reg_addr      = st_ff.addr;
	assign lnk.reg_wdata     = st_ff.wdata;
	assign lnk.frm_valid     = st_ff.frm_valid;
	assign lnk.frm_transport = pts_transport_type'(st_ff.frame_cmd[PTS_F_TR_LO +: 2]);
	assign lnk.frm_version2  = st_ff.frame_cmd[PTS_F_VER2];
	assign lnk.frm_msg       = st_ff.frame_cmd[PTS_F_MSG_LO +: 4];
	assign lnk.frm_da_match  = st_ff.frame_cmd[PTS_F_DA_HIT];

endmodule

// >>> design/pts_link_if.sv
`timescale 1ns/1ps
interface pts_link_if;
	import pts_pkg::*;
	logic                 reg_req;
	logic                 reg_we;
	logic [11:0]          reg_addr;
	logic [31:0]          reg_wdata;
	logic                 reg_ack;
	logic [31:0]          reg_rdata;
	logic                 frm_valid;
	pts_transport_type    frm_transport;
	logic                 frm_version2;
	logic [3:0]           frm_msg;
	logic                 frm_da_match;
	logic                 snap_valid;
	logic [31:0]          snap_sec;
	logic [PTS_SUB_W-1:0] snap_sub;
	logic                 trig_irq;

	modport device (
		input  reg_req, reg_we, reg_addr, reg_wdata,
		output reg_ack, reg_rdata,
		input  frm_valid, frm_transport, frm_version2, frm_msg, frm_da_match,
		output snap_valid, snap_sec, snap_sub, trig_irq
	);
	modport host (
		output reg_req, reg_we, reg_addr, reg_wdata,
		input  reg_ack, reg_rdata,
		output frm_valid, frm_transport, frm_version2, frm_msg, frm_da_match,
		input  snap_valid, snap_sec, snap_sub, trig_irq
	);
endinterface

// >>> design/pts_pkg.sv
package pts_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses, 12-bit local window)
	// ----------------------------------------------------------------
	localparam logic [11:0] PTS_OFS_CTRL     = 12'h700;
	localparam logic [11:0] PTS_OFS_INC      = 12'h704;
	localparam logic [11:0] PTS_OFS_SEC      = 12'h708;
	localparam logic [11:0] PTS_OFS_SUB      = 12'h70C;
	localparam logic [11:0] PTS_OFS_UPD_SEC  = 12'h710;
	localparam logic [11:0] PTS_OFS_UPD_SUB  = 12'h714;
	localparam logic [11:0] PTS_OFS_ADDEND   = 12'h718;
	localparam logic [11:0] PTS_OFS_TGT_SEC  = 12'h71C;
	localparam logic [11:0] PTS_OFS_TGT_SUB  = 12'h720;
	localparam logic [11:0] PTS_OFS_HI_SEC   = 12'h724;
	localparam logic [11:0] PTS_OFS_UPD_HI   = 12'h728;
	// controller's own registers
	localparam logic [11:0] PTS_OFS_FRAME    = 12'h800;
	localparam logic [11:0] PTS_OFS_STATUS   = 12'h804;
	localparam logic [11:0] PTS_OFS_SNAP_SEC = 12'h808;
	localparam logic [11:0] PTS_OFS_SNAP_SUB = 12'h80C;
	localparam int          PTS_LOCAL_BIT    = 11;

	// ----------------------------------------------------------------
	// timestamp_control fields and the update sub-second sign bit
	// ----------------------------------------------------------------
	localparam int PTS_B_ENABLE     = 0;
	localparam int PTS_B_FINE       = 1;
	localparam int PTS_B_INIT       = 2;
	localparam int PTS_B_ADJUST     = 3;
	localparam int PTS_B_TRIG_EN    = 4;
	localparam int PTS_B_ADDEND_UPD = 5;
	localparam int PTS_B_ALL_FRAMES = 8;
	localparam int PTS_B_DIGITAL    = 9;
	localparam int PTS_B_VERSION2   = 10;
	localparam int PTS_B_RAW_EN     = 11;
	localparam int PTS_B_IPV6_EN    = 12;
	localparam int PTS_B_IPV4_EN    = 13;
	localparam int PTS_B_EVENT_ONLY = 14;
	localparam int PTS_B_MASTER_SEL = 15;
	localparam int PTS_B_CLASS_LO   = 16;
	localparam int PTS_B_DA_FILTER  = 18;
	localparam logic [31:0] PTS_CTRL_MASK  = 32'h0007_FF3F;
	localparam logic [31:0] PTS_CTRL_SC    = 32'h0000_003C;
	localparam logic [31:0] PTS_CTRL_RESET = 32'h0000_2000;
	localparam int          PTS_B_UPD_NEG  = 31;

	// ----------------------------------------------------------------
	// rollover limits and widths
	// ----------------------------------------------------------------
	localparam logic [32:0] PTS_DIGITAL_MAX = 33'h0_3B9A_C9FF;
	localparam logic [32:0] PTS_BINARY_MAX  = 33'h0_07FF_FFFF;
	localparam int          PTS_INC_W       = 8;
	localparam int          PTS_SUB_W       = 31;
	localparam int          PTS_HI_W        = 16;

	// ----------------------------------------------------------------
	// frame transport and message types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PTS_TR_IPV4 = 2'h0,
		PTS_TR_IPV6 = 2'h1,
		PTS_TR_RAW  = 2'h2,
		PTS_TR_NONE = 2'h3
	} pts_transport_type;

	localparam logic [3:0] PTS_MSG_SYNC      = 4'h0;
	localparam logic [3:0] PTS_MSG_DREQ      = 4'h1;
	localparam logic [3:0] PTS_MSG_PREQ      = 4'h2;
	localparam logic [3:0] PTS_MSG_PRESP     = 4'h3;
	localparam logic [3:0] PTS_MSG_FOLLOW    = 4'h8;
	localparam logic [3:0] PTS_MSG_DRESP     = 4'h9;
	localparam logic [3:0] PTS_MSG_PFOLLOW   = 4'hA;
	localparam logic [3:0] PTS_MSG_MGMT      = 4'hD;
	localparam logic [3:0] PTS_MSG_NONE      = 4'hF;
	// version 1 control field codes
	localparam logic [3:0] PTS_V1_SYNC       = 4'h0;
	localparam logic [3:0] PTS_V1_DREQ       = 4'h1;
	localparam logic [3:0] PTS_V1_FOLLOW     = 4'h2;
	localparam logic [3:0] PTS_V1_DRESP      = 4'h3;
	localparam logic [3:0] PTS_V1_MGMT       = 4'h4;

	// controller frame command and status fields
	localparam int PTS_F_TR_LO   = 0;
	localparam int PTS_F_VER2    = 4;
	localparam int PTS_F_MSG_LO  = 8;
	localparam int PTS_F_DA_HIT  = 12;
	localparam int PTS_S_IRQ     = 16;
	localparam int PTS_CNT_W     = 16;

endpackage

// >>> design/pts_time_unit.sv
// Chosen here: the pts_link_if request/ack register port; APB is in the controller.
`timescale 1ns/1ps
module pts_time_unit
	import pts_pkg::*;
(
	input  wire logic  ref_clk,
	input  wire logic  srst,
	pts_link_if.device lnk
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0]          ctrl;
		logic [PTS_INC_W-1:0] inc;
		logic [31:0]          sec;
		logic [PTS_SUB_W-1:0] sub;
		logic [PTS_HI_W-1:0]  hi;
		logic [31:0]          upd_sec;
		logic [31:0]          upd_sub;
		logic [PTS_HI_W-1:0]  upd_hi;
		logic [31:0]          addend_reg;
		logic [31:0]          addend_act;
		logic [31:0]          acc;
		logic [31:0]          tgt_sec;
		logic [31:0]          tgt_sub;
		logic                 ack;
		logic [31:0]          rdata;
		logic                 snap_valid;
		logic [31:0]          snap_sec;
		logic [PTS_SUB_W-1:0] snap_sub;
		logic                 irq;
	} pts_dev_state_type;

	pts_dev_state_type st_ff;
	pts_dev_state_type nxt_st;

	// ----------------------------------------------------------------
	// message set selection
	// ----------------------------------------------------------------
	function automatic logic msg_selected(input logic [31:0] c, input logic [3:0] m);
		logic sy;
		logic dq;
		logic pq;
		logic pr;
		logic other;
		sy = (m == PTS_MSG_SYNC);
		dq = (m == PTS_MSG_DREQ);
		pq = (m == PTS_MSG_PREQ);
		pr = (m == PTS_MSG_PRESP);
		other = sy | dq | (m == PTS_MSG_FOLLOW) | (m == PTS_MSG_DRESP);
		msg_selected = 1'b0;
		unique case (c[PTS_B_CLASS_LO +: 2])
			2'h0: begin
				if (c[PTS_B_EVENT_ONLY])
					msg_selected = c[PTS_B_MASTER_SEL] ? dq : sy;
				else
					msg_selected = other;
			end
			2'h1: begin
				if (c[PTS_B_EVENT_ONLY])
					msg_selected = (c[PTS_B_MASTER_SEL] ? dq : sy) | pq | pr;
				else
					msg_selected = other | pq | pr | (m == PTS_MSG_PFOLLOW);
			end
			2'h2: msg_selected = sy | dq;
			2'h3: msg_selected = pq | pr;
		endcase
	endfunction

	// version 1 control codes map onto the version 2 message numbering
	function automatic logic [3:0] v1_to_msg(input logic [3:0] code);
		unique case (code)
			PTS_V1_SYNC:   v1_to_msg = PTS_MSG_SYNC;
			PTS_V1_DREQ:   v1_to_msg = PTS_MSG_DREQ;
			PTS_V1_FOLLOW: v1_to_msg = PTS_MSG_FOLLOW;
			PTS_V1_DRESP:  v1_to_msg = PTS_MSG_DRESP;
			PTS_V1_MGMT:   v1_to_msg = PTS_MSG_MGMT;
			default:       v1_to_msg = PTS_MSG_NONE;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic [32:0] lim;
	logic [32:0] sum;
	logic [32:0] acc_sum;
	logic [32:0] dsub;
	logic [31:0] dsec;
	logic        tick;
	logic        tr_ok;
	logic        msg_ok;
	logic [3:0]  msg;
	logic [31:0] wmask;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = 1'b0;
		nxt_st.snap_valid = 1'b0;
		nxt_st.irq = 1'b0;
		lim = st_ff.ctrl[PTS_B_DIGITAL] ? PTS_DIGITAL_MAX : PTS_BINARY_MAX;
		acc_sum = {1'b0, st_ff.acc} + {1'b0, st_ff.addend_act};
		tick = st_ff.ctrl[PTS_B_FINE] ? acc_sum[32] : 1'b1;
		dsub = {2'h0, st_ff.upd_sub[PTS_SUB_W-1:0]};
		dsec = st_ff.upd_sec;
		sum = '0;

		if (st_ff.ctrl[PTS_B_ENABLE]) begin
			if (st_ff.ctrl[PTS_B_FINE])
				nxt_st.acc = acc_sum[31:0];
			if (st_ff.ctrl[PTS_B_ADDEND_UPD]) begin
				nxt_st.addend_act = st_ff.addend_reg;
				nxt_st.ctrl[PTS_B_ADDEND_UPD] = 1'b0;
			end
			if (st_ff.ctrl[PTS_B_INIT]) begin
				nxt_st.sec = st_ff.upd_sec;
				nxt_st.sub = st_ff.upd_sub[PTS_SUB_W-1:0];
				nxt_st.hi = st_ff.upd_hi;
				nxt_st.ctrl[PTS_B_INIT] = 1'b0;
			end else if (st_ff.ctrl[PTS_B_ADJUST]) begin
				if (!st_ff.upd_sub[PTS_B_UPD_NEG]) begin
					sum = {2'h0, st_ff.sub} + dsub;
					if (sum > lim) begin
						sum = sum - lim - 33'h1;
						dsec = dsec + 32'h1;
					end
					nxt_st.sec = st_ff.sec + dsec;
				end else begin
					if ({2'h0, st_ff.sub} >= dsub) begin
						sum = {2'h0, st_ff.sub} - dsub;
					end else begin
						sum = {2'h0, st_ff.sub} + lim + 33'h1 - dsub;
						dsec = dsec + 32'h1;
					end
					nxt_st.sec = st_ff.sec - dsec;
				end
				nxt_st.sub = sum[PTS_SUB_W-1:0];
				nxt_st.ctrl[PTS_B_ADJUST] = 1'b0;
			end else if (tick) begin
				sum = {2'h0, st_ff.sub} + {25'h0, st_ff.inc};
				if (sum > lim) begin
					sum = sum - lim - 33'h1;
					nxt_st.sec = st_ff.sec + 32'h1;
				end
				nxt_st.sub = sum[PTS_SUB_W-1:0];
			end
			if (st_ff.ctrl[PTS_B_TRIG_EN]
			    && {st_ff.sec, st_ff.sub} > {st_ff.tgt_sec, st_ff.tgt_sub[PTS_SUB_W-1:0]}) begin
				nxt_st.irq = 1'b1;
				nxt_st.ctrl[PTS_B_TRIG_EN] = 1'b0;
			end
		end

		// snapshot decision for a received frame
		msg = lnk.frm_version2 ? lnk.frm_msg : v1_to_msg(lnk.frm_msg);
		msg_ok = (lnk.frm_version2 == st_ff.ctrl[PTS_B_VERSION2])
		         && msg_selected(st_ff.ctrl, msg);
		unique case (lnk.frm_transport)
			PTS_TR_IPV4: tr_ok = st_ff.ctrl[PTS_B_IPV4_EN];
			PTS_TR_IPV6: tr_ok = st_ff.ctrl[PTS_B_IPV6_EN];
			PTS_TR_RAW:  tr_ok = st_ff.ctrl[PTS_B_RAW_EN]
			                     && (!st_ff.ctrl[PTS_B_DA_FILTER] || lnk.frm_da_match);
			default:     tr_ok = 1'b0;
		endcase
		if (lnk.frm_valid && st_ff.ctrl[PTS_B_ENABLE]
		    && (st_ff.ctrl[PTS_B_ALL_FRAMES] || (tr_ok && msg_ok))) begin
			nxt_st.snap_valid = 1'b1;
			nxt_st.snap_sec = st_ff.sec;
			nxt_st.snap_sub = st_ff.sub;
		end

		// register access; a software set lands after the hardware clear
		wmask = lnk.reg_wdata & PTS_CTRL_MASK;
		if (!st_ff.ctrl[PTS_B_FINE])
			wmask[PTS_B_ADDEND_UPD] = 1'b0;
		if (lnk.reg_req) begin
			nxt_st.ack = 1'b1;
			nxt_st.rdata = '0;
			if (lnk.reg_we) begin
				unique case (lnk.reg_addr)
					PTS_OFS_CTRL:    nxt_st.ctrl = (wmask & ~PTS_CTRL_SC)
					                              | ((wmask | nxt_st.ctrl) & PTS_CTRL_SC);
					PTS_OFS_INC:     nxt_st.inc = lnk.reg_wdata[PTS_INC_W-1:0];
					PTS_OFS_UPD_SEC: nxt_st.upd_sec = lnk.reg_wdata;
					PTS_OFS_UPD_SUB: nxt_st.upd_sub = lnk.reg_wdata;
					PTS_OFS_ADDEND:  nxt_st.addend_reg = lnk.reg_wdata;
					PTS_OFS_TGT_SEC: nxt_st.tgt_sec = lnk.reg_wdata;
					PTS_OFS_TGT_SUB: nxt_st.tgt_sub = lnk.reg_wdata;
					PTS_OFS_UPD_HI:  nxt_st.upd_hi = lnk.reg_wdata[PTS_HI_W-1:0];
					default:         nxt_st.rdata = '0;
				endcase
			end else begin
				unique case (lnk.reg_addr)
					PTS_OFS_CTRL:    nxt_st.rdata = st_ff.ctrl;
					PTS_OFS_INC:     nxt_st.rdata = {24'h0, st_ff.inc};
					PTS_OFS_SEC:     nxt_st.rdata = st_ff.sec;
					PTS_OFS_SUB:     nxt_st.rdata = {1'b0, st_ff.sub};
					PTS_OFS_UPD_SEC: nxt_st.rdata = st_ff.upd_sec;
					PTS_OFS_UPD_SUB: nxt_st.rdata = st_ff.upd_sub;
					PTS_OFS_ADDEND:  nxt_st.rdata = st_ff.addend_reg;
					PTS_OFS_TGT_SEC: nxt_st.rdata = st_ff.tgt_sec;
					PTS_OFS_TGT_SUB: nxt_st.rdata = st_ff.tgt_sub;
					PTS_OFS_HI_SEC:  nxt_st.rdata = {16'h0, st_ff.hi};
					PTS_OFS_UPD_HI:  nxt_st.rdata = {16'h0, st_ff.upd_hi};
					default:         nxt_st.rdata = '0;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_ff <= '0;
			st_ff.ctrl <= PTS_CTRL_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign lnk.reg_ack    = st_ff.ack;
	assign lnk.reg_rdata  = st_ff.rdata;
	assign lnk.snap_valid = st_ff.snap_valid;
	assign lnk.snap_sec   = st_ff.snap_sec;
	assign lnk.snap_sub   = st_ff.snap_sub;
	assign lnk.trig_irq   = st_ff.irq;

endmodule

// >>> testbench/pts_monitor.sv
`timescale 1ns/1ps
module pts_monitor
	import pts_pkg::*;
(
	input wire logic                 ref_clk,
	input wire logic                 srst,
	input wire logic                 reg_req,
	input wire logic                 reg_we,
	input wire logic [11:0]          reg_addr,
	input wire logic [31:0]          reg_wdata,
	input wire logic                 reg_ack,
	input wire logic [31:0]          reg_rdata,
	input wire logic                 frm_valid,
	input wire pts_transport_type    frm_transport,
	input wire logic                 frm_version2,
	input wire logic [3:0]           frm_msg,
	input wire logic                 frm_da_match,
	input wire logic                 snap_valid,
	input wire logic [31:0]          snap_sec,
	input wire logic [PTS_SUB_W-1:0] snap_sub,
	input wire logic                 trig_irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// ------------------------------------------------------------
	// link checks
	// ------------------------------------------------------------
	a_ack_next: assert property (reg_req |=> reg_ack)
		else $error("register ack missing after request");
	a_ack_cause: assert property (reg_ack |-> $past(reg_req))
		else $error("register ack without request");
	a_req_held: assert property (reg_req |=> $stable(reg_addr) && $stable(reg_wdata))
		else $error("request qualifiers changed before ack");
	a_wr_rdata_zero: assert property (reg_ack && reg_we |-> reg_rdata == 32'h0)
		else $error("write ack carried read data");
	a_snap_cause: assert property (snap_valid |-> $past(frm_valid))
		else $error("snapshot without frame");
	// stamps must stand so software can read them late
	a_snap_hold: assert property (!snap_valid |-> $stable(snap_sec) && $stable(snap_sub))
		else $error("snapshot time changed without snapshot");
	a_snap_sub_max: assert property (snap_valid |-> {2'h0, snap_sub} <= PTS_DIGITAL_MAX)
		else $error("snapshot sub-second above rollover limit");
	a_irq_pulse: assert property (trig_irq |=> !trig_irq)
		else $error("trigger interrupt longer than one cycle");
	a_frame_pulse: assert property (frm_valid |=> !frm_valid)
		else $error("frame strobe longer than one cycle");
	c_snap: cover property (snap_valid);
	c_irq: cover property (trig_irq);
	c_write: cover property (reg_req && reg_we);
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) check(nm, e, g)
module tb_top;
	import pts_pkg::*;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [15:0] frame;
		logic        snap;
	} pts_row_type;
	logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, q, a;
	int          n_mismatch, comparisons, exp_cnt;
	// frame word: [1:0] transport, [4] v2, [11:8] message, [12] address hit
	pts_row_type rows [21] = '{
		'{32'h2401, 16'h0010, 1'b1}, '{32'h0401, 16'h0010, 1'b0},
		'{32'h1401, 16'h0011, 1'b1}, '{32'h2401, 16'h0011, 1'b0},
		'{32'h2401, 16'h0012, 1'b0}, '{32'h0C01, 16'h0012, 1'b1},
		'{32'h40C01, 16'h0012, 1'b0}, '{32'h40C01, 16'h1012, 1'b1},
		'{32'h2001, 16'h0010, 1'b0}, '{32'h2001, 16'h0000, 1'b1},
		'{32'h0501, 16'h0013, 1'b1},
		'{32'h22401, 16'h0010, 1'b1}, '{32'h22401, 16'h0210, 1'b0},
		'{32'h32401, 16'h0210, 1'b1}, '{32'h32401, 16'h0010, 1'b0},
		'{32'h6401, 16'h0010, 1'b1}, '{32'h6401, 16'h0110, 1'b0},
		'{32'hE401, 16'h0110, 1'b1},
		'{32'h2401, 16'h0810, 1'b1}, '{32'h2401, 16'h0D10, 1'b0},
		'{32'h2500, 16'h0010, 1'b0}
	};
	pts_link_if lnk ();
	pts_time_unit pts_time_unit_i (.ref_clk(ref_clk), .srst(srst), .lnk(lnk));
	pts_controller pts_controller_i (.ref_clk(ref_clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .lnk(lnk));
	pts_monitor pts_monitor_i (.ref_clk(ref_clk), .srst(srst), .reg_req(lnk.reg_req),
		.reg_we(lnk.reg_we), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
		.reg_ack(lnk.reg_ack), .reg_rdata(lnk.reg_rdata), .frm_valid(lnk.frm_valid),
		.frm_transport(lnk.frm_transport), .frm_version2(lnk.frm_version2),
		.frm_msg(lnk.frm_msg), .frm_da_match(lnk.frm_da_match),
		.snap_valid(lnk.snap_valid), .snap_sec(lnk.snap_sec), .snap_sub(lnk.snap_sub),
		.trig_irq(lnk.trig_irq));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// the leading edge wait keeps one idle cycle between transfers, so read spacing is fixed
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {20'h0, ad};
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d);
	endtask
	task automatic rc(input logic [11:0] ad, input logic [31:0] e);
		apb(1'b0, ad, 32'h0);
		`CHK($sformatf("reg_%h", ad), e, q);
		`CHK("pslverr", 32'h0, {31'h0, err});
	endtask
	// two device reads five cycles apart
	task automatic step(input logic [31:0] e);
		apb(1'b0, PTS_OFS_SUB, 32'h0);
		a = q;
		apb(1'b0, PTS_OFS_SUB, 32'h0);
		`CHK("sub_step", e, q - a);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, exp_cnt} = '0;
		srst = 1'b1;
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		rc(PTS_OFS_CTRL, PTS_CTRL_RESET);
		rc(PTS_OFS_INC, 32'h0);
		wr(12'h900, 32'hFFFF_FFFF);
		rc(12'h900, 32'h0);
		foreach (rows[i]) begin
			wr(PTS_OFS_CTRL, rows[i].ctrl);
			wr(PTS_OFS_FRAME, {16'h0, rows[i].frame});
			repeat (3) @(posedge ref_clk);
			exp_cnt += rows[i].snap;
			rc(PTS_OFS_STATUS, exp_cnt);
		end
		wr(PTS_OFS_CTRL, 32'h0201);
		wr(PTS_OFS_UPD_SEC, 32'hA);
		wr(PTS_OFS_UPD_SUB, 32'h1000);
		wr(PTS_OFS_UPD_HI, 32'h1234);
		wr(PTS_OFS_CTRL, 32'h0205);
		rc(PTS_OFS_CTRL, 32'h0201);
		rc(PTS_OFS_SEC, 32'hA);
		rc(PTS_OFS_SUB, 32'h1000);
		rc(PTS_OFS_HI_SEC, 32'h1234);
		wr(PTS_OFS_UPD_SEC, 32'h3);
		wr(PTS_OFS_UPD_SUB, 32'h100);
		wr(PTS_OFS_UPD_HI, 32'h55);
		wr(PTS_OFS_CTRL, 32'h0209);
		rc(PTS_OFS_CTRL, 32'h0201);
		rc(PTS_OFS_SEC, 32'hD);
		rc(PTS_OFS_SUB, 32'h1100);
		rc(PTS_OFS_HI_SEC, 32'h1234);
		wr(PTS_OFS_UPD_SEC, 32'h1);
		wr(PTS_OFS_UPD_SUB, 32'h8000_0010);
		wr(PTS_OFS_CTRL, 32'h0209);
		rc(PTS_OFS_SEC, 32'hC);
		rc(PTS_OFS_SUB, 32'h10F0);
		// increment is still zero, so the stamp must equal the adjusted time
		wr(PTS_OFS_CTRL, 32'h0301);
		wr(PTS_OFS_FRAME, 32'h0);
		repeat (3) @(posedge ref_clk);
		rc(PTS_OFS_SNAP_SEC, 32'hC);
		rc(PTS_OFS_SNAP_SUB, 32'h10F0);
		wr(PTS_OFS_CTRL, 32'h0200);
		wr(PTS_OFS_INC, 32'h14);
		step(32'h0);
		wr(PTS_OFS_CTRL, 32'h0201);
		step(32'h64);
		wr(PTS_OFS_ADDEND, 32'h0);
		wr(PTS_OFS_CTRL, 32'h0203);
		wr(PTS_OFS_CTRL, 32'h0223);
		rc(PTS_OFS_CTRL, 32'h0203);
		step(32'h0);
		wr(PTS_OFS_ADDEND, 32'hFFFF_FFFF);
		wr(PTS_OFS_CTRL, 32'h0223);
		rc(PTS_OFS_CTRL, 32'h0203);
		step(32'h64);
		wr(PTS_OFS_CTRL, 32'h0201);
		wr(PTS_OFS_UPD_SEC, 32'h5);
		wr(PTS_OFS_UPD_SUB, 32'h3B9A_C9F0);
		wr(PTS_OFS_CTRL, 32'h0205);
		rc(PTS_OFS_SEC, 32'h6);
		wr(PTS_OFS_UPD_SUB, 32'h07FF_FFF0);
		wr(PTS_OFS_CTRL, 32'h0005);
		rc(PTS_OFS_SEC, 32'h6);
		wr(PTS_OFS_INC, 32'h0);
		wr(PTS_OFS_UPD_SEC, 32'h0);
		wr(PTS_OFS_UPD_SUB, 32'h0);
		wr(PTS_OFS_CTRL, 32'h2205);
		wr(PTS_OFS_TGT_SEC, 32'h0);
		wr(PTS_OFS_TGT_SUB, 32'h200);
		wr(PTS_OFS_CTRL, 32'h2211);
		wr(PTS_OFS_INC, 32'h14);
		for (int i = 0; i < 100 && lnk.trig_irq !== 1'b1; i++) @(negedge ref_clk);
		`CHK("trig_irq", 32'h1, {31'h0, lnk.trig_irq});
		rc(PTS_OFS_CTRL, 32'h2201);
		apb(1'b0, PTS_OFS_STATUS, 32'h0);
		`CHK("irq_seen", 32'h1, {31'h0, q[PTS_S_IRQ]});
		wr(PTS_OFS_STATUS, 32'h0001_0000);
		apb(1'b0, PTS_OFS_STATUS, 32'h0);
		`CHK("irq_clear", 32'h0, {31'h0, q[PTS_S_IRQ]});
		// reset in mid-run must clear counts and time and return control to its reset value
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		rc(PTS_OFS_STATUS, 32'h0);
		rc(PTS_OFS_CTRL, PTS_CTRL_RESET);
		rc(PTS_OFS_SEC, 32'h0);
		conclude();
	end
endmodule
